// ### hdl/dbe_pkg.sv
// How it works
// RL1: address compare ignores a programmable count of low address bits.
// RL2: with data compare on, masked data must equal the compare value.
// RL3: compare value and mask are 8 bits for byte, 16 for word events.
// RL4: a zero data mask disables the data compare.
// RL5: data compare with no mask given compares every bit.
// RL6: size qualifier byte, word or any; other sizes do not match.
// RL7: software programs an even address when choosing word size.
// RL8: direction qualifier read, write or either; only that direction matches.
// RL9: break select none or event; event halts execution.
// RL10: halt on buffer full, usable alongside event break.
// RL11: trace starts at program run or at the event.
// RL12: stop-at-halt ends recording when execution halts.
// RL13: stop-on-full ends recording when the buffer fills.
// RL14: stop-on-event ends recording when the event occurs.
// RL15: full branch option stores source and target addresses.
// RL16: source-only option stores the source address only.
// RL17: data records hold direction, address, value; branch records tag, address.
// RL18: trace mode picks branch or data recording, one per run.
package dbe_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] DBE_OFS_CTRL  = 8'h00;
   localparam logic [7:0] DBE_OFS_ADDR  = 8'h04;
   localparam logic [7:0] DBE_OFS_DATA  = 8'h08;
   localparam logic [7:0] DBE_OFS_STAT  = 8'h0C;
   localparam logic [7:0] DBE_OFS_MASK  = 8'h10;
   localparam logic [7:0] DBE_OFS_TRPTR = 8'h14;
   localparam logic [7:0] DBE_OFS_TRRD  = 8'h18;
   // ctrl fields
   localparam int DBE_CB_AMASK  = 0;  // 5 bits
   localparam int DBE_CB_SIZE   = 5;  // 2 bits
   localparam int DBE_CB_DIR    = 7;  // 2 bits
   localparam int DBE_CB_DEN    = 9;
   localparam int DBE_CB_MGIVEN = 10;
   localparam int DBE_CB_BRK    = 11;
   localparam int DBE_CB_HFULL  = 12;
   localparam int DBE_CB_START  = 13;
   localparam int DBE_CB_STOPH  = 14;
   localparam int DBE_CB_STOPF  = 15;
   localparam int DBE_CB_STOPE  = 16;
   localparam int DBE_CB_MODE   = 17;
   localparam int DBE_CB_SRCO   = 18;
   localparam int DBE_CB_ARM    = 19;
   // status bits
   localparam int DBE_ST_EVT  = 0;
   localparam int DBE_ST_HALT = 1;
   localparam int DBE_ST_FULL = 2;
   localparam int DBE_ST_STOP = 3;
   localparam logic [31:0] DBE_CTRL_RST = 32'h0;
   // size / direction codes
   localparam logic [1:0] DBE_SZ_ANY  = 2'h0;
   localparam logic [1:0] DBE_SZ_BYTE = 2'h1;
   localparam logic [1:0] DBE_SZ_WORD = 2'h2;
   localparam logic [1:0] DBE_DIR_RW  = 2'h0;
   localparam logic [1:0] DBE_DIR_RD  = 2'h1;
   localparam logic [1:0] DBE_DIR_WR  = 2'h2;
   // record tags
   localparam logic [1:0] DBE_TAG_SRC = 2'h0;
   localparam logic [1:0] DBE_TAG_DST = 2'h1;
   localparam logic [1:0] DBE_TAG_RD  = 2'h2;
   localparam logic [1:0] DBE_TAG_WR  = 2'h3;

   // core bus observation and register bus request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        word;
      logic [19:0] addr;
      logic [15:0] data;
   } dbe_acc_t;

   typedef struct packed {
      logic        valid;
      logic [19:0] src;
      logic [19:0] dst;
   } dbe_br_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } dbe_wbm_t;
endpackage : dbe_pkg

// ### hdl/dbe_top.sv
`timescale 1ns/1ps
`default_nettype none
module dbe_top #(
   parameter int DEPTH = 64
) (
   input  wire logic          clk,      // 10 MHz
   input  wire logic          rst,      // async, high
   input  wire dbe_pkg::dbe_wbm_t wb_i, // wishbone request
   output logic [31:0]        wb_dat_o, // read data
   output logic               wb_ack_o, // ack
   input  wire dbe_pkg::dbe_acc_t acc_i, // core data access
   input  wire dbe_pkg::dbe_br_t  br_i,  // core branch
   input  wire logic          run_i,    // program running
   output logic               halt_o,   // halt request
   output logic               irq_o     // level interrupt
);
   import dbe_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef enum logic [1:0] {T_IDLE, T_REC, T_DST, T_DONE} dbe_tst_t;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [19:0] addr;
      logic [31:0] data;   // [15:0] compare, [31:16] mask
      logic [3:0]  stat;
      logic [3:0]  mask;
      logic        ack;
      logic [31:0] rdat;
      logic        halt;
      logic        run;
      dbe_tst_t    ts;
      logic [AW:0] cnt;
      logic [AW-1:0] rptr;
      logic [19:0] pend;
   } dbe_st_t;

   dbe_st_t q, d;
   logic [37:0] mem [DEPTH];
   logic        we_m;
   logic [37:0] wdat_m;
   logic [AW-1:0] wadr_m;
   logic        hit, hit_a, hit_d, hit_s, hit_r, full, started;
   logic        fill;
   logic [19:0] amsk;
   logic [15:0] cmp_m;
   logic [4:0]  ab;
   logic [1:0]  sz, dr;
   logic        wb_go, wb_wr;

   // ==========================================================
   // event compare
   always_comb begin
      ab = q.ctrl[DBE_CB_AMASK +: 5];
      sz = q.ctrl[DBE_CB_SIZE +: 2];
      dr = q.ctrl[DBE_CB_DIR +: 2];
      amsk = 20'hFFFFF << ab;
      hit_a = ((acc_i.addr ^ q.addr) & amsk) == 20'h0;             // RL1
      // no mask given means all bits; byte events look at low byte only
      cmp_m = q.ctrl[DBE_CB_MGIVEN] ? q.data[31:16] : 16'hFFFF;    // RL5
      if (sz == DBE_SZ_BYTE) cmp_m = {8'h00, cmp_m[7:0]};          // RL3
      hit_d = !q.ctrl[DBE_CB_DEN] || (cmp_m == 16'h0000)           // RL4
              || (((acc_i.data ^ q.data[15:0]) & cmp_m) == 16'h0); // RL2
      case (sz)                                                     // RL6
         DBE_SZ_BYTE: hit_s = !acc_i.word;
         DBE_SZ_WORD: hit_s = acc_i.word;
         default:     hit_s = 1'b1;
      endcase
      case (dr)                                                     // RL8
         DBE_DIR_RD: hit_r = !acc_i.write;
         DBE_DIR_WR: hit_r = acc_i.write;
         default:    hit_r = 1'b1;
      endcase
      hit = q.ctrl[DBE_CB_ARM] && acc_i.valid && hit_a && hit_d
            && hit_s && hit_r;
   end

   assign full    = q.cnt == (AW+1)'(DEPTH);
   assign started = run_i && !q.run;
   assign wb_go   = wb_i.cyc && wb_i.stb && !q.ack;
   assign wb_wr   = wb_go && wb_i.we;

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      we_m = 1'b0;
      wdat_m = 38'h0;
      wadr_m = q.cnt[AW-1:0];
      d.ack = wb_go;
      d.run = run_i;
      d.halt = q.halt && run_i;
      // status read clears first, so a set in the same cycle still lands
      if (wb_go && !wb_i.we && wb_i.adr == DBE_OFS_STAT)
         d.stat = 4'h0;
      if (hit) d.stat[DBE_ST_EVT] = 1'b1;
      // trace recording
      case (q.ts)
         T_IDLE: begin
            if ((q.ctrl[DBE_CB_START] ? hit : started)                // RL11
                && q.ctrl[DBE_CB_ARM])
               d.ts = T_REC;
         end
         T_REC, T_DST: begin
            if (q.ts == T_DST && !full) begin                        // RL15
               we_m = 1'b1;
               wdat_m = {DBE_TAG_DST, 16'h0, q.pend};
               d.cnt = q.cnt + 1'b1;
               d.ts = T_REC;
            end else if (q.ctrl[DBE_CB_MODE]) begin                  // RL18
               if (hit && !full) begin                               // RL17
                  we_m = 1'b1;
                  wdat_m = {acc_i.write ? DBE_TAG_WR : DBE_TAG_RD,
                            acc_i.data, acc_i.addr};
                  d.cnt = q.cnt + 1'b1;
               end
            end else if (br_i.valid && !full) begin                  // RL17
               we_m = 1'b1;
               wdat_m = {DBE_TAG_SRC, 16'h0, br_i.src};
               d.cnt = q.cnt + 1'b1;
               d.pend = br_i.dst;
               if (!q.ctrl[DBE_CB_SRCO]) d.ts = T_DST;               // RL16
            end
            if ((q.ctrl[DBE_CB_STOPH] && q.run && !run_i)            // RL12
                || (q.ctrl[DBE_CB_STOPF] && full)                    // RL13
                || (q.ctrl[DBE_CB_STOPE] && hit)) begin              // RL14
               d.ts = T_DONE;
               d.stat[DBE_ST_STOP] = 1'b1;
            end
         end
         T_DONE: ;
         default: d.ts = T_IDLE;
      endcase
      // fill pulses once; a status read must not re-arm the full halt
      fill = we_m && (q.cnt == (AW+1)'(DEPTH - 1));
      if (full) d.stat[DBE_ST_FULL] = 1'b1;
      if ((q.ctrl[DBE_CB_BRK] && hit)                                // RL9
          || (q.ctrl[DBE_CB_HFULL] && fill)) begin
         d.halt = 1'b1;                                              // RL10
         d.stat[DBE_ST_HALT] = 1'b1;
      end
      // register bus
      if (wb_go) begin
         case (wb_i.adr)
            DBE_OFS_CTRL:  d.rdat = q.ctrl;
            DBE_OFS_ADDR:  d.rdat = {12'h0, q.addr};
            DBE_OFS_DATA:  d.rdat = q.data;
            DBE_OFS_STAT:  d.rdat = {28'h0, q.stat};
            DBE_OFS_MASK:  d.rdat = {28'h0, q.mask};
            DBE_OFS_TRPTR: d.rdat = {16'h0, 8'(q.cnt), 8'(q.rptr)};
            DBE_OFS_TRRD:  d.rdat = {26'h0, mem[q.rptr][37:32]};
            default:       d.rdat = 32'h0;
         endcase
         if (wb_i.adr == DBE_OFS_TRRD && !wb_i.we) d.rdat = {
            mem[q.rptr][37:36], 10'h0, mem[q.rptr][19:0]};
      end
      if (wb_wr) begin
         case (wb_i.adr)
            DBE_OFS_CTRL: begin
               d.ctrl = wb_i.dat;
               // rewriting ctrl starts a fresh measurement
               d.ts = T_IDLE;
               d.cnt = '0;
               d.rptr = '0;
            end
            DBE_OFS_ADDR:  d.addr = wb_i.dat[19:0];                  // RL7
            DBE_OFS_DATA:  d.data = wb_i.dat;
            DBE_OFS_MASK:  d.mask = wb_i.dat[3:0];
            DBE_OFS_TRPTR: d.rptr = wb_i.dat[AW-1:0];
            default: ;
         endcase
      end
      if (wb_go && !wb_i.we && wb_i.adr == DBE_OFS_TRRD)
         d.rptr = q.rptr + 1'b1;
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge clk) begin
      if (we_m) mem[wadr_m] <= wdat_m;
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign halt_o   = q.halt;
   assign irq_o    = |(q.stat & q.mask);

   // ==========================================================
   // checks
   chk_byte_cmp: assert property (@(posedge clk) disable iff (rst)
      (q.ctrl[DBE_CB_SIZE +: 2] == DBE_SZ_BYTE && acc_i.word) |-> !hit)
      else $error("byte event hit on word access"); // RL6
   chk_dir_qual: assert property (@(posedge clk) disable iff (rst)
      (q.ctrl[DBE_CB_DIR +: 2] == DBE_DIR_RD && acc_i.write) |-> !hit)
      else $error("read event hit on write"); // RL8
   chk_break_event: assert property (@(posedge clk) disable iff (rst)
      (hit && q.ctrl[DBE_CB_BRK]) |=> halt_o)
      else $error("event break missing"); // RL9
   chk_no_break: assert property (@(posedge clk) disable iff (rst)
      (!q.ctrl[DBE_CB_BRK] && !q.ctrl[DBE_CB_HFULL] && !halt_o) |=> !halt_o)
      else $error("halt without cause"); // RL10
   chk_stop_event: assert property (@(posedge clk) disable iff (rst)
      (q.ts == T_REC && q.ctrl[DBE_CB_STOPE] && hit && !wb_wr)
      |=> q.ts == T_DONE)
      else $error("stop on event missed"); // RL14
   chk_full_stop: assert property (@(posedge clk) disable iff (rst)
      (full && q.ts == T_REC && q.ctrl[DBE_CB_STOPF] && !wb_wr)
      |=> q.ts == T_DONE)
      else $error("stop on full missed"); // RL13
   chk_src_only: assert property (@(posedge clk) disable iff (rst)
      (q.ctrl[DBE_CB_SRCO] && !wb_wr) |=> q.ts != T_DST)
      else $error("target stored in source-only"); // RL16
   chk_zero_mask: assert property (@(posedge clk) disable iff (rst) // RL4
      (q.ctrl[DBE_CB_ARM] && acc_i.valid && hit_a && hit_s && hit_r
       && cmp_m == 16'h0) |-> hit)
      else $error("zero mask still compares");

   // ==========================================================
   // event compare checks
   chk_size_word: assert property (@(posedge clk) disable iff (rst) // RL6
      (sz == DBE_SZ_WORD && !acc_i.word) |-> !hit)
      else $error("word event hit on byte access");

   chk_dir_write: assert property (@(posedge clk) disable iff (rst) // RL8
      (dr == DBE_DIR_WR && !acc_i.write) |-> !hit)
      else $error("write event hit on read");

   chk_addr_match: assert property (@(posedge clk) disable iff (rst) // RL1
      hit |-> (((acc_i.addr ^ q.addr) & (20'hFFFFF << ab)) == 20'h0))
      else $error("event hit on foreign address");

   chk_addr_ignore: assert property (@(posedge clk) disable iff (rst) // RL1
      (q.ctrl[DBE_CB_ARM] && acc_i.valid && ab >= 5'd20
       && hit_d && hit_s && hit_r) |-> hit)
      else $error("fully ignored address still compares");

   chk_data_match: assert property (@(posedge clk) disable iff (rst) // RL2
      (hit && q.ctrl[DBE_CB_DEN] && cmp_m != 16'h0)
      |-> ((acc_i.data & cmp_m) == (q.data[15:0] & cmp_m)))
      else $error("event hit on wrong data");

   chk_byte_width: assert property (@(posedge clk) disable iff (rst) // RL3
      (sz == DBE_SZ_BYTE) |-> (cmp_m[15:8] == 8'h00))
      else $error("byte event compares high byte");

   chk_word_width: assert property (@(posedge clk) disable iff (rst) // RL3
      (sz == DBE_SZ_WORD && q.ctrl[DBE_CB_MGIVEN])
      |-> (cmp_m == q.data[31:16]))
      else $error("word event mask cut");

   chk_all_bits: assert property (@(posedge clk) disable iff (rst) // RL5
      (!q.ctrl[DBE_CB_MGIVEN] && sz != DBE_SZ_BYTE)
      |-> (cmp_m == 16'hFFFF))
      else $error("missing mask does not compare all bits");

   chk_no_valid: assert property (@(posedge clk) disable iff (rst) // RL1
      !acc_i.valid |-> !hit)
      else $error("event without access");

   chk_disarmed: assert property (@(posedge clk) disable iff (rst) // RL1
      !q.ctrl[DBE_CB_ARM] |-> !hit)
      else $error("event while disarmed");

   chk_event_flag: assert property (@(posedge clk) disable iff (rst) // RL1
      hit |=> q.stat[DBE_ST_EVT])
      else $error("event flag lost");

   // ==========================================================
   // break checks
   chk_halt_flag: assert property (@(posedge clk) disable iff (rst) // RL9
      (hit && q.ctrl[DBE_CB_BRK]) |=> q.stat[DBE_ST_HALT])
      else $error("halt flag lost");

   chk_full_halt: assert property (@(posedge clk) disable iff (rst) // RL10
      (q.ctrl[DBE_CB_HFULL] && fill) |=> halt_o)
      else $error("halt on full missing");

   chk_both_break: assert property (@(posedge clk) disable iff (rst) // RL10
      (q.ctrl[DBE_CB_HFULL] && q.ctrl[DBE_CB_BRK] && hit) |=> halt_o)
      else $error("event break lost with full break");

   chk_halt_hold: assert property (@(posedge clk) disable iff (rst) // RL9
      (halt_o && run_i) |=> halt_o)
      else $error("halt dropped while running");

   chk_halt_drop: assert property (@(posedge clk) disable iff (rst) // RL9
      (halt_o && !run_i && !(q.ctrl[DBE_CB_BRK] && hit)
       && !(q.ctrl[DBE_CB_HFULL] && fill)) |=> !halt_o)
      else $error("halt kept after stop");

   // ==========================================================
   // trace checks
   chk_start_event: assert property (@(posedge clk) disable iff (rst) // RL11
      (q.ts == T_IDLE && q.ctrl[DBE_CB_ARM] && q.ctrl[DBE_CB_START]
       && hit && !wb_wr) |=> q.ts == T_REC)
      else $error("start on event missed");

   chk_start_run: assert property (@(posedge clk) disable iff (rst) // RL11
      (q.ts == T_IDLE && q.ctrl[DBE_CB_ARM] && !q.ctrl[DBE_CB_START]
       && started && !wb_wr) |=> q.ts == T_REC)
      else $error("start on run missed");

   chk_idle_quiet: assert property (@(posedge clk) disable iff (rst) // RL11
      (q.ts == T_IDLE || q.ts == T_DONE) |-> !we_m)
      else $error("record outside measurement");

   chk_halt_stop: assert property (@(posedge clk) disable iff (rst) // RL12
      (q.ts == T_REC && q.ctrl[DBE_CB_STOPH] && q.run && !run_i
       && !wb_wr) |=> q.ts == T_DONE)
      else $error("stop at halt missed");

   chk_no_overfill: assert property (@(posedge clk) disable iff (rst) // RL13
      full |-> !we_m)
      else $error("record written into full buffer");

   chk_full_flag: assert property (@(posedge clk) disable iff (rst) // RL13
      full |=> q.stat[DBE_ST_FULL])
      else $error("full flag lost");

   chk_stop_flag: assert property (@(posedge clk) disable iff (rst) // RL14
      (q.ts != T_DONE ##1 q.ts == T_DONE) |-> q.stat[DBE_ST_STOP])
      else $error("stop flag lost");

   chk_dst_store: assert property (@(posedge clk) disable iff (rst) // RL15
      (q.ts == T_DST && !full) |-> (we_m
       && wdat_m[37:36] == DBE_TAG_DST && wdat_m[19:0] == q.pend))
      else $error("target record missing");

   chk_src_store: assert property (@(posedge clk) disable iff (rst) // RL16
      (q.ts == T_REC && !q.ctrl[DBE_CB_MODE] && br_i.valid && !full)
      |-> (we_m && wdat_m[19:0] == br_i.src))
      else $error("source record missing");

   chk_data_rec: assert property (@(posedge clk) disable iff (rst) // RL17
      (q.ts == T_REC && q.ctrl[DBE_CB_MODE] && hit && !full)
      |-> (we_m && wdat_m[35:0] == {acc_i.data, acc_i.addr}))
      else $error("data record content wrong");

   chk_data_tag: assert property (@(posedge clk) disable iff (rst) // RL17
      (q.ts == T_REC && q.ctrl[DBE_CB_MODE] && hit && !full)
      |-> (wdat_m[37:36] == (acc_i.write ? DBE_TAG_WR : DBE_TAG_RD)))
      else $error("data record direction wrong");

   chk_mode_data: assert property (@(posedge clk) disable iff (rst) // RL18
      (q.ts == T_REC && q.ctrl[DBE_CB_MODE] && we_m) |-> wdat_m[37])
      else $error("branch record in data mode");

   chk_mode_branch: assert property (@(posedge clk) disable iff (rst) // RL18
      (q.ts != T_IDLE && !q.ctrl[DBE_CB_MODE] && we_m) |-> !wdat_m[37])
      else $error("data record in branch mode");

   chk_ctrl_clear: assert property (@(posedge clk) disable iff (rst) // RL18
      (wb_wr && wb_i.adr == DBE_OFS_CTRL)
      |=> (q.ts == T_IDLE && q.cnt == '0))
      else $error("control write kept old trace");

   // ==========================================================
   // register bus and interrupt checks
   chk_ack_answer: assert property (@(posedge clk) disable iff (rst)
      wb_go |=> wb_ack_o)
      else $error("request not acknowledged");

   chk_ack_once: assert property (@(posedge clk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");

   chk_irq_off: assert property (@(posedge clk) disable iff (rst)
      (q.mask == 4'h0) |-> !irq_o)
      else $error("interrupt with all sources masked");
endmodule : dbe_top
`default_nettype wire

// ### test/dbe_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// core model: replays bus events, stops when halted
module dbe_core_model (
   input  wire logic              clk,   // clock
   input  wire logic              rst,   // reset
   input  wire dbe_pkg::dbe_acc_t acc_c, // access to issue
   input  wire dbe_pkg::dbe_br_t  br_c,  // branch to issue
   input  wire logic              go,    // run command
   input  wire logic              halt,  // halt request
   output var dbe_pkg::dbe_acc_t  acc,   // core access
   output var dbe_pkg::dbe_br_t   br,    // core branch
   output var logic               run    // executing
);
   import dbe_pkg::*;
   logic held;
   // halt latches until go drops, else run would restart
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc  <= '0;
         br   <= '0;
         run  <= 1'b0;
         held <= 1'b0;
      end else begin
         acc  <= acc_c;
         br   <= br_c;
         held <= (held | halt) & go;
         run  <= go & ~held & ~halt;
      end
   end
endmodule : dbe_core_model
`default_nettype wire

// ### test/debug_event_break_trace_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("Error %0t: got %0h want %0h", $time, g, e); end end
module debug_event_break_trace_test;
   import dbe_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        go = 1'b0;
   logic        halt_seen = 1'b0;
   int          err_total = 0;
   int          check_count = 0;
   int          n;
   int          cnt [5] = '{4, 3, 1, 1, 2};
   dbe_wbm_t    wbr = '0;
   dbe_acc_t    acc_c = '0;
   dbe_br_t     br_c = '0;
   dbe_acc_t    acc, x;
   dbe_br_t     br;
   logic [31:0] rdat, q, c, dv;
   logic [19:0] ea;
   logic        ack, run, halt, irq;

   always #50 clk = ~clk;
   dbe_top #(.DEPTH(4)) dut (.clk(clk), .rst(rst), .wb_i(wbr), .wb_dat_o(rdat),
      .wb_ack_o(ack), .acc_i(acc), .br_i(br), .run_i(run), .halt_o(halt),
      .irq_o(irq));
   dbe_core_model core (.clk(clk), .rst(rst), .acc_c(acc_c), .br_c(br_c),
      .go(go), .halt(halt), .acc(acc), .br(br), .run(run));
   always @(posedge clk) if (halt === 1'b1) halt_seen <= 1'b1;

   // ====
   // tasks
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wbr <= '{1'b1, 1'b1, we, 4'hF, a, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      wbr <= '0;
      @(posedge clk);
   endtask : wb
   task automatic step(input dbe_acc_t a, input dbe_br_t b);
      acc_c <= a;
      br_c  <= b;
      @(posedge clk);
      acc_c <= '0;
      br_c  <= '0;
      repeat (4) @(posedge clk);
   endtask : step
   // control write clears the trace, run rises after it
   task automatic start(input logic [31:0] cv);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      wb(1, DBE_OFS_CTRL, cv | (32'h1 << DBE_CB_ARM));
      wb(0, DBE_OFS_STAT, 32'h0);
      halt_seen <= 1'b0;
      go <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : start
   function automatic logic hit(input logic [31:0] cv, input dbe_acc_t a);
      logic [19:0] am;
      logic [15:0] m;
      am = 20'hFFFFF << cv[4:0];
      m = cv[DBE_CB_MGIVEN] ? dv[31:16] : 16'hFFFF;
      if (cv[6:5] == DBE_SZ_BYTE) m &= 16'h00FF;
      hit = ((a.addr & am) == (ea & am))
         && (cv[6:5] == DBE_SZ_ANY || a.word == (cv[6:5] == DBE_SZ_WORD))
         && (cv[8:7] == DBE_DIR_RW || a.write == (cv[8:7] == DBE_DIR_WR))
         && (!cv[DBE_CB_DEN] || m == 0 || (a.data & m) == (dv[15:0] & m));
   endfunction : hit
   task automatic give_verdict();
      if (err_total == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // ====
   // sequence
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict();
   end
   initial begin
      c = $urandom(32'hD33B);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK(halt, 1'b0)
      wb(1, 8'h40, 32'hFFFFFFFF);
      for (int i = 0; i < 48; i++) begin
         c = $urandom & 32'hE00;
         c[4:0] = $urandom_range(4);
         c[6:5] = $urandom_range(2);
         c[8:7] = $urandom_range(2);
         ea = $urandom;
         if (c[6:5] == DBE_SZ_WORD) ea[0] = 1'b0;
         dv = $urandom;
         if (i % 5 == 0) dv[31:16] = 16'h0;
         x.valid = 1'b1;
         x.write = 1'($urandom);
         x.word = 1'($urandom);
         x.addr = ea ^ (20'($urandom_range(1)) << $urandom_range(5));
         x.data = dv[15:0] ^ (16'($urandom_range(1)) << $urandom_range(15));
         wb(1, DBE_OFS_ADDR, 32'(ea));
         wb(1, DBE_OFS_DATA, dv);
         start(c);
         step(x, '0);
         wb(0, DBE_OFS_STAT, 32'h0);
         `CHK(q[DBE_ST_EVT], hit(c, x))
         `CHK(halt_seen, c[DBE_CB_BRK] & hit(c, x))
      end
      wb(1, DBE_OFS_MASK, 32'h1 << DBE_ST_EVT);
      start(32'h14);
      step(x, '0);
      `CHK(irq, 1'b1)
      wb(0, DBE_OFS_STAT, 32'h0);
      `CHK(irq, 1'b0)
      wb(1, DBE_OFS_MASK, 32'h0);
      step(x, '0);
      `CHK(irq, 1'b0)
      start(32'h14 | (32'h1 << DBE_CB_MODE) | (32'h9 << DBE_CB_HFULL));
      for (int i = 0; i < 6; i++) begin
         x.write = i[0];
         x.addr = 20'(i * 3);
         step(x, '0);
      end
      `CHK(halt_seen, 1'b1)
      wb(0, DBE_OFS_TRPTR, 32'h0);
      `CHK(q[15:8], 8'h04)
      wb(1, DBE_OFS_TRPTR, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wb(0, DBE_OFS_TRRD, 32'h0);
         `CHK(q[31:30], i[0] ? DBE_TAG_WR : DBE_TAG_RD)
         `CHK(q[19:0], 20'(i * 3))
      end
      // full, source only, stop on event, stop at halt, start on event
      for (int k = 0; k < 5; k++) begin
         c = 32'h14;
         c[DBE_CB_SRCO] = (k > 0);
         c[DBE_CB_STOPF] = (k < 2);
         c[DBE_CB_STOPE] = (k == 2);
         c[DBE_CB_STOPH] = (k == 3);
         c[DBE_CB_BRK] = (k == 3);
         c[DBE_CB_START] = (k == 4);
         start(c);
         for (int j = 0; j < 3; j++) begin
            step('0, '{1'b1, 20'h100 + 20'(j), 20'h800 + 20'(j)});
            if (j == 0) step(x, '0);
         end
         wb(0, DBE_OFS_TRPTR, 32'h0);
         `CHK(q[15:8], 8'(cnt[k]))
         wb(1, DBE_OFS_TRPTR, 32'h0);
         for (int j = 0; j < cnt[k]; j++) begin
            wb(0, DBE_OFS_TRRD, 32'h0);
            n = (k == 0) ? j / 2 : j + (k == 4);
            `CHK(q[31:30], (k == 0 && j[0]) ? DBE_TAG_DST : DBE_TAG_SRC)
            `CHK(q[19:0], (k == 0 && j[0]) ? 20'h800 + 20'(n) : 20'h100 + 20'(n))
         end
      end
      give_verdict();
   end
endmodule : debug_event_break_trace_test
`default_nettype wire
